// file: src/spc_top.sv
// system pin control: reset, drive faults, user interrupts, clock-out, boot strap
`timescale 1ns/1ps
`default_nettype none
module spc_top #(
   parameter bit HAS_BOOT_ROM = 1'b1,
   parameter int N_PWM        = 8
)(
   input  wire logic                  core_clk,
   input  wire logic                  srst,
   input  wire spc_pkg::spc_bus_req_type bus_req,
   output var  logic [15:0]           bus_rdata,
   input  wire logic                  device_reset_n_in,
   output var  logic                  device_reset_n_out,
   output var  logic                  device_reset_n_oe,
   input  wire logic                  watchdog_overflow,
   input  wire logic                  watchdog_clock,
   input  wire logic                  drive_fault_in_a,
   input  wire logic                  drive_fault_in_b,
   input  wire logic [N_PWM-1:0]      pwm_a_in,
   input  wire logic [N_PWM-1:0]      pwm_b_in,
   output var  logic [N_PWM-1:0]      pwm_a_out,
   output var  logic [N_PWM-1:0]      pwm_a_oe,
   output var  logic [N_PWM-1:0]      pwm_b_out,
   output var  logic [N_PWM-1:0]      pwm_b_oe,
   input  wire logic                  io_port_a_bit2_in,
   output var  logic                  io_port_a_bit2_out,
   output var  logic                  io_port_a_bit2_oe,
   input  wire logic                  io_port_d_bit0_in,
   output var  logic                  io_port_d_bit0_out,
   output var  logic                  io_port_d_bit0_oe,
   input  wire logic                  io_port_e_bit0_in,
   output var  logic                  io_port_e_bit0_out,
   output var  logic                  io_port_e_bit0_oe,
   input  wire logic                  boot_en_in,
   output var  logic                  external_flag_out,
   output var  logic                  external_flag_oe,
   output var  logic                  cpu_run,
   output var  logic [15:0]           program_counter,
   output var  logic                  adc_conv_trigger_in,
   output var  logic                  irq_out
);
   import spc_pkg::*;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   localparam int NS = 8;
   logic [NS-1:0] sync1_reg;
   logic [NS-1:0] sync2_reg;
   logic [NS-1:0] prev_reg;
   logic [NS-1:0] raw_in;
   assign raw_in = {device_reset_n_in, watchdog_clock, boot_en_in, io_port_e_bit0_in,
                    io_port_d_bit0_in, io_port_a_bit2_in, drive_fault_in_b, drive_fault_in_a};

   // synchronise external inputs
   // the reset pin bit syncs to low, so the block stays held until the pin is seen high
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++)
      begin : g_sync
         always_ff @(posedge core_clk)
         begin
            if (srst)
            begin
               sync1_reg[gi] <= (gi != NS - 1);
               sync2_reg[gi] <= (gi != NS - 1);
               prev_reg[gi]  <= (gi != NS - 1);
            end
            else
            begin
               sync1_reg[gi] <= raw_in[gi];
               sync2_reg[gi] <= sync1_reg[gi];
               prev_reg[gi]  <= sync2_reg[gi];
            end
         end
      end
   endgenerate

   logic watchdog_clock_s;
   logic boot_s;
   logic rst_s;
   logic [NS-1:0] fall;
   logic [NS-1:0] rise;
   assign rst_s     = sync2_reg[7];
   assign boot_s    = sync2_reg[5];
   assign watchdog_clock_s   = sync2_reg[6];
   assign fall      = prev_reg & ~sync2_reg;
   assign rise      = ~prev_reg & sync2_reg;

   // ----------------------------------------
   // reset sequencing and registers
   // ----------------------------------------
   spc_state_type state_reg, state_next;
   logic [7:0]  pulse_cnt_reg, pulse_cnt_next;
   logic [15:0] pc_reg, pc_next;
   logic [15:0] sys_ctrl_reg, sys_ctrl_next;
   logic        boot_reg, boot_next;
   logic        flag_reg, flag_next;
   logic [3:0]  stat_reg, stat_next;
   logic [3:0]  mask_reg, mask_next;
   logic [2:0]  dir_reg, dir_next;
   logic [2:0]  gout_reg, gout_next;
   logic [15:0] ctrl_reg, ctrl_next;
   logic [15:0] rdata_next;
   logic        held;
   logic [3:0]  events;
   logic        wr_on;
   logic        rd_on;

   assign held  = (state_reg != SPC_RUN);
   assign wr_on = bus_req.wr && !held;
   assign rd_on = bus_req.rd && !held;

   assign events[EV_FAULT_A] = fall[0];
   assign events[EV_FAULT_B] = fall[1];
   assign events[EV_USER_1]  = ctrl_reg[CTRL_POL1_BIT] ? rise[2] : fall[2];
   assign events[EV_USER_2]  = ctrl_reg[CTRL_POL2_BIT] ? rise[3] : fall[3];

   always_comb
   begin
      state_next     = state_reg;
      pulse_cnt_next = pulse_cnt_reg;
      pc_next        = pc_reg;
      sys_ctrl_next  = sys_ctrl_reg;
      boot_next      = boot_reg;
      flag_next      = flag_reg;
      stat_next      = stat_reg;
      mask_next      = mask_reg;
      dir_next       = dir_reg;
      gout_next      = gout_reg;
      ctrl_next      = ctrl_reg;
      rdata_next     = ZERO16;
      case (state_reg)
         SPC_HELD:
         begin
            if (rst_s)
               state_next = SPC_RUN;
         end
         SPC_RUN:
         begin
            pc_next = pc_reg + 16'h0001;
            if (watchdog_overflow)
            begin
               state_next     = SPC_WD_PULSE;
               pulse_cnt_next = 8'(RESET_PULSE_CYC - 1);
            end
            else if (!rst_s)
               state_next = SPC_HELD;
         end
         SPC_WD_PULSE:
         begin
            if (pulse_cnt_reg == 8'h00)
               state_next = SPC_HELD;
            else
               pulse_cnt_next = pulse_cnt_reg - 8'h01;
         end
         default:
            state_next = SPC_HELD;
      endcase

      if (wr_on)
      begin
         case (bus_req.addr)
            ADDR_SYS_CTRL:   sys_ctrl_next = bus_req.wdata;
            ADDR_SYS_CTRL2:  flag_next = bus_req.wdata[FLAG_BIT];
            ADDR_IRQ_MASK:   mask_next = bus_req.wdata[3:0];
            ADDR_GPIO_DIR:   dir_next  = bus_req.wdata[2:0];
            ADDR_GPIO_OUT:   gout_next = bus_req.wdata[2:0];
            ADDR_CTRL:       ctrl_next = bus_req.wdata;
            default:         ;
         endcase
      end
      if (rd_on)
      begin
         case (bus_req.addr)
            ADDR_SYS_CTRL:   rdata_next = sys_ctrl_reg;
            ADDR_SYS_CTRL2:  rdata_next = {12'h000, boot_reg, 2'b00, flag_reg};
            ADDR_IRQ_STATUS: rdata_next = {12'h000, stat_reg};
            ADDR_IRQ_MASK:   rdata_next = {12'h000, mask_reg};
            ADDR_GPIO_DIR:   rdata_next = {13'h0000, dir_reg};
            ADDR_GPIO_OUT:   rdata_next = {13'h0000, gout_reg};
            ADDR_GPIO_IN:    rdata_next = {13'h0000, sync2_reg[4:2]};
            ADDR_CTRL:       rdata_next = ctrl_reg;
            default:         rdata_next = ZERO16;
         endcase
         // read of status clears it
         if (bus_req.addr == ADDR_IRQ_STATUS)
            stat_next = 4'h0;
      end
      // pending flags, set wins over clear
      stat_next = stat_next | events;

      // held state stops and zeroes pc
      if (held)
      begin
         pc_next   = ZERO16;
         sys_ctrl_next = SYS_CTRL_RESET;
         flag_next = 1'b0;
         stat_next = 4'h0;
         mask_next = 4'h0;
         // GPIO pins come up as inputs
         dir_next  = 3'b000;
         gout_next = 3'b000;
         ctrl_next = CTRL_RESET;
         // no boot ROM, no strap mode
         boot_next = HAS_BOOT_ROM ? boot_s : 1'b0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state_reg     <= SPC_HELD;
         pulse_cnt_reg <= 8'h00;
         pc_reg        <= ZERO16;
         sys_ctrl_reg  <= SYS_CTRL_RESET;
         boot_reg      <= 1'b0;
         flag_reg      <= 1'b0;
         stat_reg      <= 4'h0;
         mask_reg      <= 4'h0;
         dir_reg       <= 3'b000;
         gout_reg      <= 3'b000;
         ctrl_reg      <= CTRL_RESET;
         bus_rdata     <= ZERO16;
      end
      else
      begin
         state_reg     <= state_next;
         pulse_cnt_reg <= pulse_cnt_next;
         pc_reg        <= pc_next;
         sys_ctrl_reg  <= sys_ctrl_next;
         boot_reg      <= boot_next;
         flag_reg      <= flag_next;
         stat_reg      <= stat_next;
         mask_reg      <= mask_next;
         dir_reg       <= dir_next;
         gout_reg      <= gout_next;
         ctrl_reg      <= ctrl_next;
         bus_rdata     <= rdata_next;
      end
   end

   // ----------------------------------------
   // pin drivers, all registered
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         device_reset_n_out  <= 1'b0;
         device_reset_n_oe   <= 1'b0;
         pwm_a_out           <= '0;
         pwm_a_oe            <= '0;
         pwm_b_out           <= '0;
         pwm_b_oe            <= '0;
         io_port_a_bit2_out  <= 1'b0;
         io_port_a_bit2_oe   <= 1'b0;
         io_port_d_bit0_out  <= 1'b0;
         io_port_d_bit0_oe   <= 1'b0;
         io_port_e_bit0_out  <= 1'b0;
         io_port_e_bit0_oe   <= 1'b0;
         external_flag_out   <= 1'b0;
         external_flag_oe    <= 1'b0;
         cpu_run             <= 1'b0;
         program_counter     <= ZERO16;
         adc_conv_trigger_in <= 1'b0;
         irq_out             <= 1'b0;
      end
      else
      begin
         device_reset_n_out  <= 1'b0;
         device_reset_n_oe   <= (state_next == SPC_WD_PULSE);
         pwm_a_out           <= pwm_a_in;
         pwm_a_oe            <= {N_PWM{!held && !stat_next[EV_FAULT_A]}};
         pwm_b_out           <= pwm_b_in;
         pwm_b_oe            <= {N_PWM{!held && !stat_next[EV_FAULT_B]}};
         io_port_a_bit2_out  <= gout_next[0];
         io_port_a_bit2_oe   <= dir_next[0] && !ctrl_next[CTRL_PIN_FN_BIT];
         io_port_d_bit0_out  <= gout_next[1];
         io_port_d_bit0_oe   <= dir_next[1] && !ctrl_next[CTRL_PIN_FN_BIT];
         io_port_e_bit0_out  <= ctrl_next[CTRL_CLK_FN_BIT]
                                ? (sys_ctrl_reg[CLK_OUT_SEL_BIT] ? watchdog_clock_s : ~io_port_e_bit0_out)
                                : gout_next[2];
         io_port_e_bit0_oe   <= ctrl_next[CTRL_CLK_FN_BIT] ? !held : dir_next[2];
         external_flag_out   <= flag_next;
         external_flag_oe    <= !held;
         cpu_run             <= (state_next == SPC_RUN);
         program_counter     <= pc_next;
         adc_conv_trigger_in <= events[EV_USER_2] && ctrl_reg[CTRL_SOC_EN_BIT] && !held;
         irq_out             <= |(stat_next & mask_next);
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_pc_zero_held: assert property (@(posedge core_clk) disable iff (srst)
      held |=> program_counter == ZERO16) else $error("pc not zero while held");
   a_start_at_zero: assert property (@(posedge core_clk) disable iff (srst)
      state_reg == SPC_HELD && rst_s |=> pc_reg == ZERO16 ##1 pc_reg == 16'h0001)
      else $error("execution did not start at zero");
   a_regs_cleared: assert property (@(posedge core_clk) disable iff (srst)
      held |=> mask_reg == 4'h0 && stat_reg == 4'h0) else $error("regs not cleared in reset");
   a_wd_pulse_out: assert property (@(posedge core_clk) disable iff (srst)
      state_reg == SPC_RUN && watchdog_overflow |=> device_reset_n_oe [*8])
      else $error("watchdog reset pulse missing");
   a_fault_a_off: assert property (@(posedge core_clk) disable iff (srst)
      fall[0] |=> pwm_a_oe == '0) else $error("group A not tri-stated");
   a_fault_b_off: assert property (@(posedge core_clk) disable iff (srst)
      fall[1] |=> pwm_b_oe == '0) else $error("group B not tri-stated");
   a_fault_fall_only: assert property (@(posedge core_clk) disable iff (srst)
      rise[0] && !held && $past(stat_reg[0]) == 1'b0 && !stat_reg[0] |=> !stat_reg[0])
      else $error("fault flagged on rising edge");
   a_gpio_input: assert property (@(posedge core_clk) disable iff (srst)
      held |=> !io_port_a_bit2_oe && !io_port_d_bit0_oe) else $error("gpio driven during reset");
   a_boot_sample: assert property (@(posedge core_clk) disable iff (srst)
      held && HAS_BOOT_ROM |=> boot_reg == $past(boot_s)) else $error("boot strap not sampled");
   c_wd_reset: cover property (@(posedge core_clk) state_reg == SPC_WD_PULSE);
   c_fault_a: cover property (@(posedge core_clk) fall[0] && !held);
   c_user2_soc: cover property (@(posedge core_clk) adc_conv_trigger_in);
   c_irq: cover property (@(posedge core_clk) irq_out);
endmodule
`default_nettype wire

// file: src/spc_pkg.sv
// package of constants and carrier types for the system pin control block
`default_nettype none
package spc_pkg;
   localparam int          ADDR_W           = 4;
   localparam int          DATA_W           = 16;
   localparam logic [3:0]  ADDR_SYS_CTRL    = 4'h0;
   localparam logic [3:0]  ADDR_SYS_CTRL2   = 4'h1;
   localparam logic [3:0]  ADDR_IRQ_STATUS  = 4'h2;
   localparam logic [3:0]  ADDR_IRQ_MASK    = 4'h3;
   localparam logic [3:0]  ADDR_GPIO_DIR    = 4'h4;
   localparam logic [3:0]  ADDR_GPIO_OUT    = 4'h5;
   localparam logic [3:0]  ADDR_GPIO_IN     = 4'h6;
   localparam logic [3:0]  ADDR_CTRL        = 4'h7;
   localparam int          CLK_OUT_SEL_BIT  = 14;
   localparam int          BOOT_EN_BIT      = 3;
   localparam int          FLAG_BIT         = 0;
   localparam int          WD_OVF_BIT       = 15;
   // irq status / mask / ctrl bit positions
   localparam int          EV_FAULT_A       = 0;
   localparam int          EV_FAULT_B       = 1;
   localparam int          EV_USER_1        = 2;
   localparam int          EV_USER_2        = 3;
   localparam int          CTRL_POL1_BIT    = 0;
   localparam int          CTRL_POL2_BIT    = 1;
   localparam int          CTRL_SOC_EN_BIT  = 2;
   localparam int          CTRL_PIN_FN_BIT  = 3;
   localparam int          CTRL_CLK_FN_BIT  = 4;
   localparam logic [15:0] SYS_CTRL_RESET   = 16'h0000;
   localparam logic [15:0] CTRL_RESET       = 16'h0010;
   localparam logic [15:0] ZERO16           = 16'h0000;
   localparam int          RESET_PULSE_NS   = 640;
   localparam int          CLK_PERIOD_NS    = 5;
   localparam int          RESET_PULSE_CYC  = RESET_PULSE_NS / CLK_PERIOD_NS;
   localparam int          PC_W             = 16;

   typedef struct packed
   {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } spc_bus_req_type;

   typedef struct packed
   {
      logic o;
      logic oe;
   } spc_pin_drv_type;

   typedef enum logic [1:0]
   {
      SPC_HELD    = 2'b00,
      SPC_RUN     = 2'b01,
      SPC_WD_PULSE = 2'b11
   } spc_state_type;
endpackage
`default_nettype wire

// file: tb/spc_board.sv
// board model: pulled-up reset wire, fault detectors, boot strap, watchdog clock
`timescale 1ns/1ps
`default_nettype none
module spc_board (
   input  wire logic core_clk,
   input  wire logic hold_n,
   input  wire logic fault_a,
   input  wire logic fault_b,
   input  wire logic strap,
   input  wire logic rst_pin_out,
   input  wire logic rst_pin_oe,
   output var  logic rst_pin,
   output var  logic fault_a_n,
   output var  logic fault_b_n,
   output var  logic boot_pin,
   output var  logic wd_clk
);
   logic [2:0] div_reg = 3'h0;

   // open-drain pull-up wire
   // the wire is low while the board switch or the device pulls it
   assign rst_pin   = hold_n & ~(rst_pin_oe & ~rst_pin_out);
   assign fault_a_n = ~fault_a;
   assign fault_b_n = ~fault_b;
   assign boot_pin  = strap;
   // slow free-running clock: one toggle every four core cycles
   assign wd_clk    = div_reg[2];

   always @(posedge core_clk)
   begin
      div_reg <= div_reg + 3'h1;
   end
endmodule
`default_nettype wire

// file: tb/spc_bench.sv
// self-checking bench for the system pin control block
`timescale 1ns/1ps
`default_nettype none
module spc_bench;
   import spc_pkg::*;
   logic            core_clk, srst, wd_ovf, hold_n, fa, fb, a2_in, d0_in, pv, rd_seen;
   logic            rst_pin, fa_n, fb_n, boot_pin, wd_clk, rst_out, rst_oe, flag, flag_oe;
   logic            a2_out, a2_oe, d0_out, d0_oe, e0_out, e0_oe, run, adc, irq;
   logic [7:0]      pwm_a, pwm_b, pa_out, pa_oe, pb_out, pb_oe;
   logic [15:0]     rdata, pc, e, exp_q[$];
   spc_bus_req_type req;
   int              error_cnt = 0, checks = 0, cyc = 0, adc_cnt = 0, seed = 91, n, i, p;

   spc_board board (.core_clk(core_clk), .hold_n(hold_n), .fault_a(fa), .fault_b(fb),
      .strap(1'b1), .rst_pin_out(rst_out), .rst_pin_oe(rst_oe), .rst_pin(rst_pin),
      .fault_a_n(fa_n), .fault_b_n(fb_n), .boot_pin(boot_pin), .wd_clk(wd_clk));

   spc_top dut (.core_clk(core_clk), .srst(srst), .bus_req(req), .bus_rdata(rdata),
      .device_reset_n_in(rst_pin), .device_reset_n_out(rst_out), .device_reset_n_oe(rst_oe),
      .watchdog_overflow(wd_ovf), .watchdog_clock(wd_clk), .drive_fault_in_a(fa_n),
      .drive_fault_in_b(fb_n), .pwm_a_in(pwm_a), .pwm_b_in(pwm_b), .pwm_a_out(pa_out),
      .pwm_a_oe(pa_oe), .pwm_b_out(pb_out), .pwm_b_oe(pb_oe), .io_port_a_bit2_in(a2_in),
      .io_port_a_bit2_out(a2_out), .io_port_a_bit2_oe(a2_oe), .io_port_d_bit0_in(d0_in),
      .io_port_d_bit0_out(d0_out), .io_port_d_bit0_oe(d0_oe), .io_port_e_bit0_in(1'b0),
      .io_port_e_bit0_out(e0_out), .io_port_e_bit0_oe(e0_oe), .boot_en_in(boot_pin),
      .external_flag_out(flag), .external_flag_oe(flag_oe), .cpu_run(run),
      .program_counter(pc), .adc_conv_trigger_in(adc), .irq_out(irq));

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task conclude;
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task cmp_rd(input logic [15:0] got);
      if (exp_q.size() == 0)
         chk(got, 16'hFFFF, "read without note");
      else
      begin
         e = exp_q.pop_front();
         chk(got, e, "read data");
      end
   endtask

   task step(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
      req <= '0;
   endtask

   task rd(input logic [3:0] a, input logic [15:0] x);
      exp_q.push_back(x);
      @(posedge core_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge core_clk);
      req <= '0;
   endtask

   task wait_run;
      n = 0;
      while (run !== 1'b1 && n < 40)
      begin
         step(1);
         n++;
      end
      chk({15'h0, run}, 16'h0001, "run wait");
   endtask

   // ----------------------------------------------------------------
   // result watcher and hang guard
   // ----------------------------------------------------------------
   always @(posedge core_clk)
   begin
      rd_seen <= req.rd;
      if (adc === 1'b1)
         adc_cnt++;
      cyc++;
      if (cyc >= 20000)
      begin
         error_cnt++;
         conclude;
      end
   end

   always @(negedge core_clk)
      if (rd_seen === 1'b1)
         cmp_rd(rdata);

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      srst = 1'b1;
      req = '0;
      wd_ovf = 1'b0;
      hold_n = 1'b0;
      fa = 1'b0;
      fb = 1'b0;
      a2_in = 1'b0;
      d0_in = 1'b0;
      rd_seen = 1'b0;
      pwm_a = 8'($random(seed));
      pwm_b = 8'($random(seed));
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      step(6);
      chk({run, pc[14:0]}, 16'h0000, "held");
      chk({pa_oe, pb_oe}, 16'h0000, "pwm held");
      @(posedge core_clk) hold_n <= 1'b1;
      wait_run;
      chk(pc, 16'h0000, "pc start");
      step(1);
      chk(pc, 16'h0001, "pc step");
      chk({14'h0, a2_oe, d0_oe}, 16'h0000, "gpio oe");
      rd(ADDR_SYS_CTRL, SYS_CTRL_RESET);
      rd(ADDR_CTRL, CTRL_RESET);
      rd(ADDR_GPIO_DIR, ZERO16);
      rd(ADDR_IRQ_MASK, ZERO16);
      rd(ADDR_SYS_CTRL2, 16'h0001 << BOOT_EN_BIT);
      rd(4'hF, ZERO16);
      wr(ADDR_SYS_CTRL2, 16'h0001);
      step(2);
      chk({14'h0, flag, flag_oe}, 16'h0003, "flag out");
      rd(ADDR_SYS_CTRL2, 16'h0009);
      // clock pin: core_clk/2 toggles every cycle, watchdog clock every four
      for (p = 0; p < 2; p++)
      begin
         wr(ADDR_SYS_CTRL, p ? 16'h4000 : 16'h0000);
         step(6);
         pv = e0_out;
         n = 0;
         repeat (32)
         begin
            step(1);
            if (e0_out !== pv)
               n++;
            pv = e0_out;
         end
         chk(16'(n), p ? 16'd8 : 16'd32, "clock out edges");
         chk({15'h0, e0_oe}, 16'h0001, "clock out drive");
      end
      wr(ADDR_SYS_CTRL, 16'h0000);
      chk({pa_out, pb_out}, {pwm_a, pwm_b}, "pwm pass");
      chk({pa_oe, pb_oe}, 16'hFFFF, "pwm drive");
      wr(ADDR_IRQ_MASK, 16'h000F);
      for (i = 0; i < 2; i++)
      begin
         @(posedge core_clk)
         begin
            fa <= (i == 0);
            fb <= (i == 1);
         end
         step(6);
         chk({pa_oe, pb_oe}, i ? 16'hFF00 : 16'h00FF, "fault oe");
         chk({15'h0, irq}, 16'h0001, "fault irq");
         rd(ADDR_IRQ_STATUS, 16'h0001 << i);
         step(3);
         chk({pa_oe, pb_oe}, 16'hFFFF, "fault clear");
         chk({15'h0, irq}, 16'h0000, "fault irq clear");
         @(posedge core_clk)
         begin
            fa <= 1'b0;
            fb <= 1'b0;
         end
         step(6);
         rd(ADDR_IRQ_STATUS, ZERO16);
      end
      for (p = 1; p >= 0; p--)
      begin
         wr(ADDR_CTRL, CTRL_RESET | 16'h0004 | (p ? 16'h0003 : 16'h0000));
         @(posedge core_clk)
         begin
            a2_in <= p[0];
            d0_in <= p[0];
         end
         step(6);
         rd(ADDR_IRQ_STATUS, 16'h000C);
      end
      @(posedge core_clk)
      begin
         a2_in <= 1'b1;
         d0_in <= 1'b1;
      end
      step(6);
      rd(ADDR_IRQ_STATUS, ZERO16);
      step(2);
      chk(16'(adc_cnt), 16'd2, "adc trigger pulses");
      wr(ADDR_GPIO_DIR, 16'h0003);
      wr(ADDR_GPIO_OUT, 16'h0002);
      step(1);
      chk({12'h0, a2_out, a2_oe, d0_out, d0_oe}, 16'h0007, "gpio drive");
      rd(ADDR_GPIO_IN, 16'h0003);
      wr(ADDR_CTRL, CTRL_RESET | 16'h0008);
      step(1);
      chk({14'h0, a2_oe, d0_oe}, 16'h0000, "gpio pin function");
      @(posedge core_clk) wd_ovf <= 1'b1;
      @(posedge core_clk) wd_ovf <= 1'b0;
      #1;
      n = 0;
      while (rst_oe === 1'b1 && n < 300)
      begin
         n++;
         step(1);
         if (n == 64)
            chk({run, pc[13:0], rst_pin}, 16'h0000, "wd held");
      end
      chk(16'(n), 16'(RESET_PULSE_CYC), "wd pulse length");
      wait_run;
      chk(pc, 16'h0000, "pc restart");
      conclude;
   end
endmodule
`default_nettype wire
